/* File: logic/sac_defines.svh */
// register map, field positions, reset values and timing counts of the converter control
`ifndef SAC_DEFINES_SVH
`define SAC_DEFINES_SVH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define SAC_IDX_MODE      16'hFFC4
`define SAC_IDX_RESULT    16'hFFC5
`define SAC_IDX_START     16'hFFC6
`define SAC_IDX_IRQ_STAT  16'hFFC7
`define SAC_IDX_IRQ_CLR   16'hFFC8
`define SAC_IDX_IRQ_EN    16'hFFC9
`define SAC_IDX_TRIG_CFG  16'hFFCA

// ****************************************
// field positions
// ****************************************
`define SAC_MODE_SPD_LO   7
`define SAC_MODE_EXT_EN   6
`define SAC_MODE_SPD_HI   5
`define SAC_START_FLAG    7
`define SAC_TRIG_PIN_FN   0
`define SAC_TRIG_EDGE     1
`define SAC_IRQ_END       0

// ****************************************
// reset values and masks
// ****************************************
`define SAC_MODE_RST      8'h10
`define SAC_MODE_WMASK    8'hEF
`define SAC_MODE_RSV      8'h10
`define SAC_START_RSV     7'h7F

// ****************************************
// conversion timing in system clocks
// ****************************************
`define SAC_PER_SLOW      8'h7C
`define SAC_PER_MID       8'h3E
`define SAC_PER_FAST      8'h1F
`define SAC_BIT_SLOW      8'h0C
`define SAC_BIT_MID       8'h06
`define SAC_BIT_FAST      8'h03

`endif

/* File: logic/sac_pkg.sv */
// types and decode helpers shared by the converter control
package sac_pkg;
`include "sac_defines.svh"

	typedef enum logic [1:0] {
		SAC_IDLE,
		SAC_SAMPLE,
		SAC_BITS
	} sac_state_t;

	// 00 = no channel, 01 = analog_in_six, 10 = analog_in_seven
	typedef struct packed {
		logic       sample;
		logic [7:0] code;
		logic [1:0] chan;
	} sac_afe_t;

	function automatic logic [7:0] sac_period(input logic [1:0] spd);
		unique case (spd)
			2'h1:    return `SAC_PER_SLOW;
			2'h2:    return `SAC_PER_MID;
			2'h3:    return `SAC_PER_FAST;
			default: return `SAC_PER_SLOW;
		endcase
	endfunction : sac_period

	function automatic logic [7:0] sac_bit_len(input logic [1:0] spd);
		unique case (spd)
			2'h1:    return `SAC_BIT_SLOW;
			2'h2:    return `SAC_BIT_MID;
			2'h3:    return `SAC_BIT_FAST;
			default: return `SAC_BIT_SLOW;
		endcase
	endfunction : sac_bit_len

	function automatic logic [7:0] sac_sample_len(input logic [1:0] spd);
		logic [7:0] slot;
		slot = sac_bit_len(spd);
		return sac_period(spd) - {slot[4:0], 3'h0};
	endfunction : sac_sample_len

	function automatic logic [1:0] sac_chan_decode(input logic [3:0] ch);
		if (ch == 4'hA)
			return 2'h1;
		else if (ch == 4'hB)
			return 2'h2;
		else
			return 2'h0;
	endfunction : sac_chan_decode

endpackage : sac_pkg

/* File: logic/sac_top.sv */
// successive-approximation converter control with a classic wishbone register slave
// ****************************************
// How it works
// - successive approximation yields an 8-bit result
// - result register read-only, readable any time
// - result held until next conversion completes
// - reset leaves result register untouched
// - mode register resets to 0x10
// - speed bits pick 124, 62, 31 clocks
// - mode bit 6 gates trigger pin starts
// - reserved mode and start bits read one
// - channel code 1010 six, 1011 seven
// - start bit write 1 starts, 0 aborts
// - start flag clears when result is stored
// - completion sets end request, enable gates irq
// - trigger needs pin function and enable bit
// - return to idle until started again
// ****************************************
`timescale 1ns/10ps

`include "sac_defines.svh"

module sac_top
	import sac_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic [31:0] adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic        we_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	output      logic [31:0] dat_o,
	output      logic        ack_o,
	// trigger pin and comparator
	input  wire logic        ext_start_pin_i,
	input  wire logic        cmp_i,
	// analog front end and interrupt
	output      sac_afe_t    afe_o,
	output      logic        irq_o
);

	// ****************************************
	// state
	// ****************************************
	logic [7:0]  conversion_mode;
	logic [7:0]  conversion_result;
	logic        trigger_pin_function;
	logic        trigger_edge_select;
	logic        conv_end_request;
	logic        conv_end_irq_enable;
	sac_state_t  state;
	logic [7:0]  timer;
	logic [2:0]  bit_idx;
	logic [7:0]  sar;
	logic [1:0]  conv_speed;
	logic        pin_meta;
	logic        pin_sync;
	logic        pin_prev;
	logic [1:0]  pin_arm;
	logic [7:0]  rd_data;
	logic        next_request;
	logic        next_irq_enable;

	function automatic logic reg_hit(input logic [31:0] adr, input logic [15:0] idx);
		return (adr[31:18] == 14'h0) && (adr[17:2] == idx);
	endfunction : reg_hit

	// ****************************************
	// bus decode
	// ****************************************
	// writes land on the edge where the master sees ack, reads are captured a cycle earlier
	wire bus_req    = cyc_i & stb_i & ~ack_o;
	wire wb_wr      = cyc_i & stb_i & ack_o & we_i & sel_i[0];
	wire wr_mode    = wb_wr & reg_hit(adr_i, `SAC_IDX_MODE);
	wire wr_start   = wb_wr & reg_hit(adr_i, `SAC_IDX_START);
	wire wr_clr     = wb_wr & reg_hit(adr_i, `SAC_IDX_IRQ_CLR);
	wire wr_en      = wb_wr & reg_hit(adr_i, `SAC_IDX_IRQ_EN);
	wire wr_trig    = wb_wr & reg_hit(adr_i, `SAC_IDX_TRIG_CFG);
	wire start_wr1  = wr_start & dat_i[`SAC_START_FLAG];
	wire start_wr0  = wr_start & ~dat_i[`SAC_START_FLAG];

	wire       busy     = (state != SAC_IDLE);
	wire [1:0] mode_spd = {conversion_mode[`SAC_MODE_SPD_HI], conversion_mode[`SAC_MODE_SPD_LO]};
	wire [7:0] start_rd = {busy, `SAC_START_RSV};

	// ****************************************
	// trigger pin
	// ****************************************
	wire trig_edge = (pin_arm == 2'h3) &
		(trigger_edge_select ? (pin_sync & ~pin_prev) : (~pin_sync & pin_prev));
	wire trig_ok   = trigger_pin_function & conversion_mode[`SAC_MODE_EXT_EN];
	wire trig_go   = trig_edge & trig_ok & ~busy;

	// software write wins over a coinciding trigger edge
	wire begin_conv = ~busy & (start_wr1 | (trig_go & ~wr_start));
	wire abort      = busy & start_wr0;

	// ****************************************
	// bit decision
	// ****************************************
	wire [7:0] bit_mask = 8'h01 << bit_idx;
	wire [7:0] decided  = cmp_i ? sar : (sar & ~bit_mask);
	wire [7:0] next_try = decided | (8'h01 << (bit_idx - 3'h1));
	wire       done_now = (state == SAC_BITS) & (timer == 8'h00) & (bit_idx == 3'h0) & ~abort;

	// pin_meta feeds only pin_sync
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta <= 1'b0;
			pin_sync <= 1'b0;
			pin_prev <= 1'b0;
			pin_arm  <= 2'h0;
		end else begin
			pin_meta <= ext_start_pin_i;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
			// no edge until the chain holds real pin samples
			if (pin_arm != 2'h3)
				pin_arm <= pin_arm + 2'h1;
		end
	end

	// ****************************************
	// mode and trigger configuration
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conversion_mode <= `SAC_MODE_RST;
		end else if (wr_mode) begin
			conversion_mode <= (dat_i[7:0] & `SAC_MODE_WMASK) | `SAC_MODE_RSV;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trigger_pin_function <= 1'b0;
			trigger_edge_select  <= 1'b0;
		end else if (wr_trig) begin
			trigger_pin_function <= dat_i[`SAC_TRIG_PIN_FN];
			trigger_edge_select  <= dat_i[`SAC_TRIG_EDGE];
		end
	end

	// ****************************************
	// conversion sequencer
	// ****************************************
	// speed is latched at start; a mid-conversion change is only seen next time
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state      <= SAC_IDLE;
			timer      <= 8'h00;
			bit_idx    <= 3'h0;
			sar        <= 8'h00;
			conv_speed <= 2'h0;
			afe_o      <= '0;
		end else begin
			afe_o.chan <= sac_chan_decode(conversion_mode[3:0]);
			if (abort) begin
				state        <= SAC_IDLE;
				afe_o.sample <= 1'b0;
			end else if (begin_conv) begin
				state        <= SAC_SAMPLE;
				conv_speed   <= mode_spd;
				timer        <= sac_sample_len(mode_spd) - 8'h01;
				sar          <= 8'h00;
				afe_o.sample <= 1'b1;
				afe_o.code   <= 8'h00;
			end else begin
				unique case (state)
					SAC_IDLE: begin
						state <= SAC_IDLE;
					end
					SAC_SAMPLE: begin
						if (timer == 8'h00) begin
							state        <= SAC_BITS;
							timer        <= sac_bit_len(conv_speed) - 8'h01;
							bit_idx      <= 3'h7;
							sar          <= 8'h80;
							afe_o.sample <= 1'b0;
							afe_o.code   <= 8'h80;
						end else begin
							timer <= timer - 8'h01;
						end
					end
					SAC_BITS: begin
						if (timer != 8'h00) begin
							timer <= timer - 8'h01;
						end else if (bit_idx == 3'h0) begin
							state      <= SAC_IDLE;
							sar        <= decided;
							afe_o.code <= decided;
						end else begin
							bit_idx    <= bit_idx - 3'h1;
							timer      <= sac_bit_len(conv_speed) - 8'h01;
							sar        <= next_try;
							afe_o.code <= next_try;
						end
					end
				endcase
			end
		end
	end

	// no reset: the last result survives a chip reset
	// a completion landing on a reset edge is dropped, not stored
	always_ff @(posedge clk_i) begin
		if (!rst_i && done_now)
			conversion_result <= decided;
	end

	// ****************************************
	// interrupt
	// ****************************************
	// a completion in the clearing cycle still sets the request
	always_comb begin
		next_request    = done_now |
			(conv_end_request & ~(wr_clr & dat_i[`SAC_IRQ_END]));
		next_irq_enable = wr_en ? dat_i[`SAC_IRQ_END] : conv_end_irq_enable;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_end_request    <= 1'b0;
			conv_end_irq_enable <= 1'b0;
			irq_o               <= 1'b0;
		end else begin
			conv_end_request    <= next_request;
			conv_end_irq_enable <= next_irq_enable;
			irq_o               <= next_request & next_irq_enable;
		end
	end

	// ****************************************
	// register read and ack
	// ****************************************
	always_comb begin
		rd_data = 8'h00;
		if (reg_hit(adr_i, `SAC_IDX_MODE))
			rd_data = conversion_mode;
		else if (reg_hit(adr_i, `SAC_IDX_RESULT))
			rd_data = conversion_result;
		else if (reg_hit(adr_i, `SAC_IDX_START))
			rd_data = start_rd;
		else if (reg_hit(adr_i, `SAC_IDX_IRQ_STAT))
			rd_data = {7'h00, conv_end_request};
		else if (reg_hit(adr_i, `SAC_IDX_IRQ_EN))
			rd_data = {7'h00, conv_end_irq_enable};
		else if (reg_hit(adr_i, `SAC_IDX_TRIG_CFG))
			rd_data = {6'h00, trigger_edge_select, trigger_pin_function};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= bus_req;
			dat_o <= (bus_req & ~we_i) ? {24'h0, rd_data} : 32'h0;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	logic [7:0] busy_cnt;
	logic       result_valid;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_cnt <= 8'h00;
		end else if (begin_conv) begin
			busy_cnt <= 8'h01;
		end else if (busy) begin
			busy_cnt <= busy_cnt + 8'h01;
		end
	end

	// no reset, like the result it shadows, so reset checks keep working
	always_ff @(posedge clk_i) begin
		if (!rst_i && done_now)
			result_valid <= 1'b1;
	end

	sequence s_conv_done;
		done_now;
	endsequence

	sequence s_conv_begun;
		begin_conv ##1 busy;
	endsequence

	chk_mode_reset: assert property (@(posedge clk_i)
		$fell(rst_i) |-> conversion_mode == `SAC_MODE_RST)
		else $error("mode register not 0x10 after reset");

	chk_reserved_ones: assert property (@(posedge clk_i) disable iff (rst_i)
		conversion_mode[4] && (start_rd[6:0] == `SAC_START_RSV))
		else $error("reserved bits do not read as one");

	chk_period_len: assert property (@(posedge clk_i) disable iff (rst_i)
		s_conv_done |-> busy_cnt == sac_period(conv_speed))
		else $error("conversion length does not match speed setting");

	chk_done_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		s_conv_done |=> !busy && conv_end_request && conversion_result == $past(decided))
		else $error("completion did not store result, clear flag and raise request");

	chk_result_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		result_valid && !done_now |=> $stable(conversion_result))
		else $error("result changed without a completion");

	chk_abort_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		abort |-> !done_now ##1 !busy)
		else $error("abort did not stop the conversion quietly");

	chk_start_stays: assert property (@(posedge clk_i) disable iff (rst_i)
		s_conv_begun |-> busy [*8])
		else $error("start flag fell too early");

	chk_trig_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		trig_edge && !trig_ok && !busy && !wr_start |=> !busy)
		else $error("disabled trigger started a conversion");

	chk_trig_start: assert property (@(posedge clk_i) disable iff (rst_i)
		trig_edge && trig_ok && !busy && !wr_start |=> busy)
		else $error("enabled trigger edge did not start a conversion");

	chk_chan_decode: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> afe_o.chan == sac_chan_decode($past(conversion_mode[3:0])))
		else $error("channel select does not follow the channel field");

	chk_idle_stays: assert property (@(posedge clk_i) disable iff (rst_i)
		!busy && !begin_conv |=> !busy)
		else $error("converter left idle without a start");

	chk_result_reset: assert property (@(posedge clk_i)
		rst_i && result_valid |=> $stable(conversion_result))
		else $error("reset disturbed the stored result");

	chk_sample_open: assert property (@(posedge clk_i) disable iff (rst_i)
		begin_conv |=> afe_o.sample && (afe_o.code == 8'h00))
		else $error("conversion did not open with a sample phase");

	chk_abort_no_req: assert property (@(posedge clk_i) disable iff (rst_i)
		abort && !conv_end_request |=> !conv_end_request)
		else $error("abort raised the end request");

	chk_req_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
		conv_end_request && !(wr_clr && dat_i[`SAC_IRQ_END]) |=> conv_end_request)
		else $error("end request dropped without a clear");

	chk_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_o == (conv_end_request && conv_end_irq_enable))
		else $error("interrupt line does not follow request and enable");

	chk_trig_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
		trig_edge && trig_ok && busy && !abort && !done_now |=> busy && (busy_cnt != 8'h01))
		else $error("trigger edge restarted a running conversion");

	chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held for more than one cycle");

endmodule : sac_top

/* File: test/sac_afe_model.sv */
// analog front end model: two input levels behind one comparator
`timescale 1ns/10ps

module sac_afe_model
	import sac_pkg::*;
(
	// ladder side
	input  wire sac_afe_t   afe_i,
	// input levels
	input  wire logic [7:0] six_i,
	input  wire logic [7:0] seven_i,
	// comparator
	output      logic       cmp_o
);
	logic [7:0] level;

	// no channel selected reads as ground
	always_comb begin
		case (afe_i.chan)
			2'h1:    level = six_i;
			2'h2:    level = seven_i;
			default: level = 8'h00;
		endcase
	end

	assign cmp_o = (level >= afe_i.code);

endmodule : sac_afe_model

/* File: test/sac_top_tb.sv */
// self-checking bench for the converter control
`timescale 1ns/10ps

module sac_top_tb;
	import sac_pkg::*;

	localparam logic [31:0] A_MODE = 32'h0003FF10;
	localparam logic [31:0] A_RES  = 32'h0003FF14;
	localparam logic [31:0] A_STRT = 32'h0003FF18;
	localparam logic [31:0] A_STAT = 32'h0003FF1C;
	localparam logic [31:0] A_CLR  = 32'h0003FF20;
	localparam logic [31:0] A_EN   = 32'h0003FF24;
	localparam logic [31:0] A_TRIG = 32'h0003FF28;

	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [31:0] adr_i = 32'h0;
	logic [31:0] dat_i = 32'h0;
	logic [3:0]  sel_i = 4'h0;
	logic        we_i  = 1'b0;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        ext_start_pin_i = 1'b0;
	logic [7:0]  lvl_six = 8'h0;
	logic [7:0]  lvl_seven = 8'h0;
	logic [7:0]  last_res;
	wire logic [31:0] dat_o;
	wire logic   ack_o;
	wire logic   irq_o;
	wire logic   cmp_i;
	sac_afe_t    afe_o;
	int          n_fail = 0;
	int          comparisons = 0;
	logic [7:0]  exp_q[$];

	sac_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
		.we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o),
		.ext_start_pin_i(ext_start_pin_i), .cmp_i(cmp_i), .afe_o(afe_o), .irq_o(irq_o));

	sac_afe_model afe_u (.afe_i(afe_o), .six_i(lvl_six), .seven_i(lvl_seven), .cmp_o(cmp_i));

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	// ****************************************
	// checking and closing
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] expv);
		comparisons++;
		if (seen !== expv) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
		end
	endtask : check

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_sim

	task automatic timeout();
		n_fail++;
		$display("[FAIL] %0t wait ran out", $time);
		end_sim();
	endtask : timeout

	// read data is compared against the oldest note at the ack edge
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && cyc_i === 1'b1) begin
			if (exp_q.size() == 0)
				timeout();
			else
				check(dat_o[7:0], exp_q.pop_front());
		end
	end

	initial begin
		repeat (100000) @(posedge clk_i);
		timeout();
	end

	// ****************************************
	// bus and conversion helpers
	// ****************************************
	task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
		int k;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		sel_i <= 4'hF;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack_o !== 1'b1 && k < 50);
		if (k >= 50)
			timeout();
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask : bus

	task automatic rd(input logic [31:0] a, input logic [7:0] expv);
		exp_q.push_back(expv);
		bus(1'b0, a, 8'h00);
	endtask : rd

	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic wait_irq(output int n);
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (irq_o !== 1'b1 && n < 300);
		if (n >= 300)
			timeout();
	endtask : wait_irq

	task automatic settle();
		repeat (2) @(posedge clk_i);
		#1;
	endtask : settle

	task automatic convert(input logic [1:0] spd, input logic [3:0] ch);
		int n;
		int per;
		per = (spd == 2'h2) ? 62 : (spd == 2'h3) ? 31 : 124;
		wr(A_MODE, {spd[0], 1'b0, spd[1], 1'b0, ch});
		// levels come by non-blocking assignment, so take them after the write
		last_res = (ch == 4'hA) ? lvl_six : lvl_seven;
		rd(A_MODE, {spd[0], 1'b0, spd[1], 1'b1, ch});
		wr(A_STRT, 8'h80);
		wait_irq(n);
		check(n[7:0], per[7:0]);
		check({6'h0, afe_o.chan}, (ch == 4'hA) ? 8'h01 : 8'h02);
		rd(A_RES, last_res);
		rd(A_STRT, 8'h7F);
		rd(A_STAT, 8'h01);
		wr(A_CLR, 8'h01);
		settle();
		check({7'h0, irq_o}, 8'h00);
	endtask : convert

	task automatic pin(input logic v, input int hold);
		@(posedge clk_i);
		ext_start_pin_i <= v;
		repeat (hold) @(posedge clk_i);
	endtask : pin

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		int n;
		void'($urandom(32'h943d));
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(A_MODE, 8'h10);
		rd(A_STRT, 8'h7F);
		wr(32'h0003FF30, 8'hFF);
		rd(32'h0003FF30, 8'h00);
		wr(A_MODE, 8'h00);
		rd(A_MODE, 8'h10);
		wr(A_STRT, 8'h7F);
		rd(A_STRT, 8'h7F);
		$display("test registers done");
		wr(A_EN, 8'h01);
		for (int s = 0; s < 4; s++) begin
			for (int c = 0; c < 2; c++) begin
				lvl_six   <= 8'($urandom());
				lvl_seven <= 8'($urandom());
				convert(2'(s), c ? 4'hB : 4'hA);
			end
		end
		$display("test speeds and channels done");
		lvl_six <= 8'($urandom());
		wr(A_MODE, 8'h8A);
		wr(A_STRT, 8'h80);
		rd(A_STRT, 8'hFF);
		rd(A_RES, last_res);
		wr(A_STRT, 8'h00);
		rd(A_STRT, 8'h7F);
		repeat (140) @(posedge clk_i);
		rd(A_STAT, 8'h00);
		rd(A_RES, last_res);
		$display("test abort done");
		wr(A_EN, 8'h00);
		wr(A_STRT, 8'h80);
		repeat (130) @(posedge clk_i);
		#1;
		check({7'h0, irq_o}, 8'h00);
		rd(A_STAT, 8'h01);
		wr(A_EN, 8'h01);
		settle();
		check({7'h0, irq_o}, 8'h01);
		wr(A_CLR, 8'h01);
		settle();
		check({7'h0, irq_o}, 8'h00);
		last_res = lvl_six;
		$display("test interrupt mask done");
		wr(A_TRIG, 8'h03);
		wr(A_MODE, 8'hAA);
		pin(1'b1, 8);
		pin(1'b0, 8);
		rd(A_STRT, 8'h7F);
		wr(A_MODE, 8'hEA);
		wr(A_TRIG, 8'h02);
		pin(1'b1, 8);
		pin(1'b0, 8);
		rd(A_STRT, 8'h7F);
		wr(A_TRIG, 8'h03);
		pin(1'b1, 8);
		rd(A_STRT, 8'hFF);
		pin(1'b0, 2);
		pin(1'b1, 2);
		wait_irq(n);
		repeat (20) @(posedge clk_i);
		rd(A_STRT, 8'h7F);
		wr(A_CLR, 8'h01);
		wr(A_TRIG, 8'h01);
		lvl_six <= 8'($urandom());
		pin(1'b0, 2);
		wait_irq(n);
		rd(A_RES, lvl_six);
		rd(A_STRT, 8'h7F);
		last_res = lvl_six;
		$display("test trigger done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(A_RES, last_res);
		rd(A_MODE, 8'h10);
		$display("test reset keeps result done");
		end_sim();
	end

endmodule : sac_top_tb
